// file: charge_seq_pkg.sv
/*
  Shared constants and types for the battery charge sequencer: timing figures,
  register offsets and reset values, the sequencer states and the signal bundles.
  Assumes a single 20 MHz clock domain; every count of cycles is derived here.
*/
package charge_seq_pkg;

  // ==========================================================================
  // clock and timing figures
  localparam int CLK_PERIOD_NS = 50;
  localparam int CLK_HZ = 1_000_000_000 / CLK_PERIOD_NS;
  localparam int PWM_FREQ_HZ = 1_000_000;
  localparam int PWM_CYCLES = CLK_HZ / PWM_FREQ_HZ;
  localparam int TICK_PERIOD_US = 1000;
  localparam int TICK_CYCLES = (CLK_HZ / 1_000_000) * TICK_PERIOD_US;
  localparam int FLASH_PERIOD_MS = 2000;
  localparam int FLASH_HALF_TICKS = (FLASH_PERIOD_MS * 1000) / (2 * TICK_PERIOD_US);
  localparam int PRECHARGE_TIMEOUT_TICKS = 1800;
  localparam int DUTY_W = 5;

  // ==========================================================================
  // register map and reset values
  localparam int REG_AW = 4;
  localparam int REG_DW = 16;
  localparam logic [REG_AW-1:0] OFS_CONTROL = 4'h0;
  localparam logic [REG_AW-1:0] OFS_SAFETY_LEN = 4'h1;
  localparam logic [REG_AW-1:0] OFS_STATUS = 4'h2;
  localparam logic [REG_AW-1:0] OFS_SAFETY_COUNT = 4'h3;
  localparam int CTRL_FLASH_BIT = 0;
  localparam logic RST_FLASH_MODE = 1'b0;
  localparam logic [REG_DW-1:0] RST_SAFETY_LEN = 16'h3840;
  localparam int STAT_SUSPEND_BIT = 3;
  localparam int STAT_PRE_FAULT_BIT = 4;
  localparam int STAT_SAFE_FAULT_BIT = 5;
  localparam int STAT_PINS_LSB = 6;

  // ==========================================================================
  // sequencer states and current selection
  typedef enum logic [2:0] {
    ST_SLEEP = 3'h0,
    ST_DISABLED = 3'h1,
    ST_PRECHARGE = 3'h2,
    ST_FAST = 3'h3,
    ST_VREG = 3'h4,
    ST_DONE = 3'h5,
    ST_PRE_FAULT = 3'h6,
    ST_SAFE_FAULT = 3'h7
  } chg_state_t;

  typedef enum logic [1:0] {
    CUR_NONE = 2'h0,
    CUR_PRECHARGE = 2'h1,
    CUR_FAST = 2'h2,
    CUR_DETECT = 2'h3
  } cur_sel_t;

  // ==========================================================================
  // signal bundles
  typedef struct packed {
    logic supply_ok;
    logic charge_enable_n;
    logic in_above_bat;
    logic temp_ok;
    logic above_precharge_exit;
    logic below_recharge;
    logic at_reg_voltage;
    logic at_term_current;
    logic over_discharge;
    logic timer_ctl_enabled;
    logic timer_ctl_tied_high;
    logic battery_replaced;
    logic hs_peak_limit;
    logic ls_above_min;
  } compare_t;

  typedef struct packed {
    logic high_side;
    logic low_side;
    logic input_block;
  } gate_t;

  typedef struct packed {
    logic supply_good_n;
    logic status_out_b;
    logic status_out_a;
  } od_t;

endpackage

// file: battery_charge_sequencer.sv
/*
  Charge-control sequencer: precharge, fast charge, voltage regulation,
  termination and recharge, safety timers, suspend, status pins and the
  digital switching decisions of the converter.
  Assumes analog comparator results arrive asynchronously and a small
  software port with one-cycle read latency; one 20 MHz clock only.
*/
// Strobed register access and the register addresses were decided locally.
// Overview of operation
// - start charging only inside temperature window
// - suspend stops switching and freezes timers
// - below precharge level selects precharge current
// - precharge phase runs its own timer
// - precharge timeout: stop, fault, detection current
// - precharge fault cleared by reset or replacement
// - regulation phase ends at termination current
// - programmable charge safety timer ends charging
// - recharge level, power-up, enable toggle restart
// - timer control low disables termination and timer
// - timer control rising re-enables, zeroes timer
// - timer control tied high disables timer only
// - supply loss enters sleep
// - steady status encoding of the two outputs
// - flashing status encoding at half hertz
// - fixed 1 MHz switching, 0 to 100% duty
// - peak current ends high-side on-time
// - low side synchronous only above minimum current
// - input switch off while input below battery
// - enable pin falling edge clears timers, faults
// - supply-good output on unless sleeping
`timescale 1ns/10ps
module battery_charge_sequencer
  import charge_seq_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES,
  parameter int PRECHARGE_TICKS = PRECHARGE_TIMEOUT_TICKS
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic reset_in,
  // asynchronous comparator results
  input wire compare_t compare_in,
  // duty request from the regulation loop, same clock
  input wire logic [DUTY_W-1:0] duty_level_in,
  // software port
  input wire logic [REG_AW-1:0] reg_addr_in,
  input wire logic [REG_DW-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [REG_DW-1:0] reg_rdata_out,
  // converter drive and current selection
  output gate_t gate_out,
  output cur_sel_t current_sel_out,
  // open-drain pins
  input wire od_t od_level_in,
  output od_t od_drive_out,
  output od_t od_oe_out
);

  // ==========================================================================
  // synchronisers
  compare_t meta_r;
  compare_t cmp_r;
  compare_t cmp_d_r;
  od_t pin_meta_r;
  od_t pin_r;

  // two stages before any logic reads a comparator; a third keeps the edge history
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      meta_r <= '0;
      cmp_r <= '0;
      cmp_d_r <= '0;
    end else begin
      meta_r <= compare_in;
      cmp_r <= meta_r;
      cmp_d_r <= cmp_r;
    end
  end

  // pin readback, for software only
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      pin_meta_r <= '0;
      pin_r <= '0;
    end else begin
      pin_meta_r <= od_level_in;
      pin_r <= pin_meta_r;
    end
  end

  // ==========================================================================
  // events and qualifiers
  chg_state_t state_r;
  logic enable_fall;
  logic timer_ctl_rise;
  logic replaced_rise;
  logic term_enable;
  logic safety_enable;

  // enable is active low, so a falling edge means charging was re-allowed
  assign enable_fall = cmp_d_r.charge_enable_n && !cmp_r.charge_enable_n;
  // not taken while asleep: the cleared history flop would fake a rise at power-up
  assign timer_ctl_rise = !cmp_d_r.timer_ctl_enabled && cmp_r.timer_ctl_enabled &&
                          state_r != ST_SLEEP;
  assign replaced_rise = !cmp_d_r.battery_replaced && cmp_r.battery_replaced;
  assign term_enable = cmp_r.timer_ctl_enabled;
  assign safety_enable = cmp_r.timer_ctl_enabled && !cmp_r.timer_ctl_tied_high;

  // ==========================================================================
  // time base
  logic [31:0] tick_cnt_r;
  logic tick_r;

  // one pulse per millisecond drives every slow counter
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      tick_cnt_r <= '0;
      tick_r <= 1'b0;
    end else if (tick_cnt_r == 32'(TICK_LEN - 1)) begin
      tick_cnt_r <= '0;
      tick_r <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h1;
      tick_r <= 1'b0;
    end
  end

  // ==========================================================================
  // software registers
  logic flash_mode_r;
  logic [REG_DW-1:0] safety_len_r;

  // writes to read-only or unmapped offsets are dropped
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      flash_mode_r <= RST_FLASH_MODE;
      safety_len_r <= RST_SAFETY_LEN;
    end else if (reg_wr_in) begin
      if (reg_addr_in == OFS_CONTROL) begin
        flash_mode_r <= reg_wdata_in[CTRL_FLASH_BIT];
      end else if (reg_addr_in == OFS_SAFETY_LEN) begin
        safety_len_r <= reg_wdata_in;
      end
    end
  end

  // ==========================================================================
  // sequencer
  chg_state_t state_nxt;
  chg_state_t start_state;
  logic charging;
  logic suspended;
  logic [31:0] pre_cnt_r;
  logic [REG_DW-1:0] safety_cnt_r;
  logic safety_expired;

  assign charging = (state_r == ST_PRECHARGE) || (state_r == ST_FAST) || (state_r == ST_VREG);
  assign suspended = charging && !cmp_r.temp_ok;
  assign safety_expired = safety_enable && (safety_cnt_r >= safety_len_r);
  // deeply discharged cells start gently
  assign start_state = cmp_r.above_precharge_exit ? ST_FAST : ST_PRECHARGE;

  // priority: supply, enable pin, restart events, then phase progress
  always_comb begin
    state_nxt = state_r;
    if (!cmp_r.supply_ok) begin
      state_nxt = ST_SLEEP;
    end else if (cmp_r.charge_enable_n) begin
      state_nxt = ST_DISABLED;
    end else if (enable_fall || timer_ctl_rise) begin
      state_nxt = start_state;
    end else begin
      case (state_r)
        ST_SLEEP, ST_DISABLED: begin
          // a full battery at power-up waits for the recharge level
          state_nxt = cmp_r.below_recharge ? start_state : ST_DONE;
        end
        ST_PRECHARGE: begin
          if (!suspended) begin
            if (cmp_r.above_precharge_exit) begin
              state_nxt = ST_FAST;
            end else if (pre_cnt_r >= 32'(PRECHARGE_TICKS)) begin
              state_nxt = ST_PRE_FAULT;
            end
          end
        end
        ST_FAST: begin
          if (!suspended) begin
            if (safety_expired) begin
              state_nxt = ST_SAFE_FAULT;
            end else if (cmp_r.at_reg_voltage) begin
              state_nxt = ST_VREG;
            end
          end
        end
        ST_VREG: begin
          if (!suspended) begin
            if (safety_expired) begin
              state_nxt = ST_SAFE_FAULT;
            end else if (term_enable && cmp_r.at_term_current) begin
              state_nxt = ST_DONE;
            end
          end
        end
        ST_DONE, ST_SAFE_FAULT: begin
          if (cmp_r.below_recharge) begin
            state_nxt = start_state;
          end
        end
        ST_PRE_FAULT: begin
          if (replaced_rise) begin
            state_nxt = start_state;
          end
        end
        default: state_nxt = ST_SLEEP;
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      state_r <= ST_SLEEP;
    end else begin
      state_r <= state_nxt;
    end
  end

  // precharge timer: zero outside the phase, held while suspended
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      pre_cnt_r <= '0;
    end else if (enable_fall || state_r != ST_PRECHARGE) begin
      pre_cnt_r <= '0;
    end else if (tick_r && !suspended && pre_cnt_r < 32'(PRECHARGE_TICKS)) begin
      pre_cnt_r <= pre_cnt_r + 32'h1;
    end
  end

  // safety timer covers fast charge and regulation; saturates at the limit
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      safety_cnt_r <= '0;
    end else if (enable_fall || timer_ctl_rise || !charging) begin
      safety_cnt_r <= '0;
    end else if (tick_r && !suspended && safety_enable && state_r != ST_PRECHARGE &&
                 safety_cnt_r < safety_len_r) begin
      safety_cnt_r <= safety_cnt_r + 16'h1;
    end
  end

  // ==========================================================================
  // converter switching
  logic [DUTY_W-1:0] pwm_cnt_r;
  logic limit_hit_r;
  logic pwm_on;
  logic hs_nxt;

  assign pwm_on = charging && !suspended;
  // duty at or above the period length gives 100%, zero gives 0%
  assign hs_nxt = pwm_on && (pwm_cnt_r < duty_level_in) && !limit_hit_r &&
                  !cmp_r.hs_peak_limit;

  // fixed period counter
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      pwm_cnt_r <= '0;
    end else if (pwm_cnt_r == DUTY_W'(PWM_CYCLES - 1)) begin
      pwm_cnt_r <= '0;
    end else begin
      pwm_cnt_r <= pwm_cnt_r + DUTY_W'(1);
    end
  end

  // a limit hit holds the high side off until the next period; set wins
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      limit_hit_r <= 1'b0;
    end else if (cmp_r.hs_peak_limit) begin
      limit_hit_r <= 1'b1;
    end else if (pwm_cnt_r == DUTY_W'(PWM_CYCLES - 1)) begin
      limit_hit_r <= 1'b0;
    end
  end

  // gates come from flops; low side only while current is well forward
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      gate_out <= '0;
    end else begin
      gate_out.high_side <= hs_nxt;
      gate_out.low_side <= pwm_on && !hs_nxt && cmp_r.ls_above_min;
      gate_out.input_block <= cmp_r.supply_ok && cmp_r.in_above_bat;
    end
  end

  // analog current target follows the phase
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      current_sel_out <= CUR_NONE;
    end else begin
      case (state_r)
        ST_PRECHARGE: current_sel_out <= CUR_PRECHARGE;
        ST_FAST, ST_VREG: current_sel_out <= CUR_FAST;
        ST_PRE_FAULT: current_sel_out <= CUR_DETECT;
        default: current_sel_out <= CUR_NONE;
      endcase
    end
  end

  // ==========================================================================
  // status pins
  logic [31:0] flash_cnt_r;
  logic flash_r;
  logic flash_cond;

  // exactly FLASH_HALF_TICKS ticks per half so on and off match
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      flash_cnt_r <= '0;
      flash_r <= 1'b0;
    end else if (tick_r) begin
      if (flash_cnt_r == 32'(FLASH_HALF_TICKS - 1)) begin
        flash_cnt_r <= '0;
        flash_r <= !flash_r;
      end else begin
        flash_cnt_r <= flash_cnt_r + 32'h1;
      end
    end
  end

  assign flash_cond = suspended || state_r == ST_PRE_FAULT || state_r == ST_SAFE_FAULT ||
                      (charging && cmp_r.over_discharge);

  // outputs are plain enables; the pin level itself is always low when driven
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      od_oe_out <= '0;
    end else begin
      od_oe_out.supply_good_n <= state_r != ST_SLEEP && cmp_r.supply_ok;
      od_oe_out.status_out_b <= state_r == ST_DONE;
      if (flash_mode_r && flash_cond) begin
        od_oe_out.status_out_a <= flash_r;
      end else begin
        od_oe_out.status_out_a <= charging && !suspended;
      end
    end
  end

  assign od_drive_out = '0;

  // ==========================================================================
  // register readback
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      reg_rdata_out <= '0;
    end else if (reg_rd_in) begin
      if (reg_addr_in == OFS_CONTROL) begin
        reg_rdata_out <= {15'h0, flash_mode_r};
      end else if (reg_addr_in == OFS_SAFETY_LEN) begin
        reg_rdata_out <= safety_len_r;
      end else if (reg_addr_in == OFS_STATUS) begin
        reg_rdata_out <= {7'h0, pin_r, state_r == ST_SAFE_FAULT, state_r == ST_PRE_FAULT,
                          suspended, state_r};
      end else if (reg_addr_in == OFS_SAFETY_COUNT) begin
        reg_rdata_out <= safety_cnt_r;
      end else begin
        reg_rdata_out <= '0;
      end
    end else begin
      reg_rdata_out <= '0;
    end
  end

  // ==========================================================================
  // checks
  logic quiet;
  assign quiet = cmp_r.supply_ok && !cmp_r.charge_enable_n && !enable_fall && !timer_ctl_rise;

  property p_suspend_freeze;
    @(posedge clock_in) disable iff (reset_in)
    suspended && !enable_fall && !timer_ctl_rise |=>
      $stable(pre_cnt_r) && $stable(safety_cnt_r) && !gate_out.high_side;
  endproperty
  a_suspend_freeze: assert property (p_suspend_freeze)
    else $error("timers moved or high side on while suspended");

  property p_pre_timeout;
    @(posedge clock_in) disable iff (reset_in)
    quiet && state_r == ST_PRECHARGE && !suspended && !cmp_r.above_precharge_exit &&
      pre_cnt_r >= 32'(PRECHARGE_TICKS) |=> state_r == ST_PRE_FAULT ##1
      current_sel_out == CUR_DETECT;
  endproperty
  a_pre_timeout: assert property (p_pre_timeout)
    else $error("precharge timeout did not fault");

  property p_fault_sticky;
    @(posedge clock_in) disable iff (reset_in)
    quiet && state_r == ST_PRE_FAULT && !replaced_rise |=> state_r == ST_PRE_FAULT;
  endproperty
  a_fault_sticky: assert property (p_fault_sticky)
    else $error("precharge fault cleared without cause");

  property p_terminate;
    @(posedge clock_in) disable iff (reset_in)
    quiet && state_r == ST_VREG && !suspended && !safety_expired &&
      cmp_r.at_term_current |=> (state_r == ST_DONE) == $past(term_enable);
  endproperty
  a_terminate: assert property (p_terminate)
    else $error("termination decision wrong");

  property p_timer_zero;
    @(posedge clock_in) disable iff (reset_in)
    timer_ctl_rise |=> safety_cnt_r == 16'h0;
  endproperty
  a_timer_zero: assert property (p_timer_zero)
    else $error("safety timer not zeroed on timer control rise");

  property p_sleep;
    @(posedge clock_in) disable iff (reset_in)
    !cmp_r.supply_ok |=> state_r == ST_SLEEP ##1 !od_oe_out.supply_good_n;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("no sleep after supply loss");

  property p_steady_done;
    @(posedge clock_in) disable iff (reset_in)
    !flash_mode_r && state_r == ST_DONE |=> od_oe_out.status_out_b && !od_oe_out.status_out_a;
  endproperty
  a_steady_done: assert property (p_steady_done)
    else $error("complete status encoding wrong");

  property p_flash_tick;
    @(posedge clock_in) disable iff (reset_in)
    flash_r != $past(flash_r) |-> $past(tick_r) && $past(flash_cnt_r) == 32'(FLASH_HALF_TICKS - 1);
  endproperty
  a_flash_tick: assert property (p_flash_tick)
    else $error("flash toggled off its half period");

  property p_peak_limit;
    @(posedge clock_in) disable iff (reset_in)
    cmp_r.hs_peak_limit && pwm_cnt_r < DUTY_W'(PWM_CYCLES - 1) |=> !gate_out.high_side ##1
      !gate_out.high_side;
  endproperty
  a_peak_limit: assert property (p_peak_limit)
    else $error("high side stayed on after peak limit");

  property p_low_side;
    @(posedge clock_in) disable iff (reset_in)
    !cmp_r.ls_above_min || gate_out.high_side |-> ##1 !(gate_out.low_side && !$past(cmp_r.ls_above_min));
  endproperty
  a_low_side: assert property (p_low_side)
    else $error("low side on below minimum current");

  property p_block;
    @(posedge clock_in) disable iff (reset_in)
    !cmp_r.in_above_bat |=> !gate_out.input_block;
  endproperty
  a_block: assert property (p_block)
    else $error("input switch on while input below battery");

endmodule

// file: battery_pack_model.sv
/*
  Far-side model: the battery pack comparator levels and the pulled-up
  status lines read by LEDs or a host.
  Assumes the bench sets the pack condition; pins rise to the pull-up level.
*/
`timescale 1ns/10ps
module battery_pack_model
  import charge_seq_pkg::*;
(
  // pack condition set by the bench
  input wire compare_t cond_in,
  // open-drain transistors of the sequencer
  input wire od_t oe_in,
  input wire od_t drive_in,
  // comparator levels and resolved pin levels
  output compare_t compare_out,
  output od_t level_out
);
  // ==========================================================================
  // pack and pins
  // enable line is held low while the outside party lets charging run
  assign compare_out = cond_in;
  // pull-up on every released pin, so a released line never shows stale data
  assign level_out = (oe_in & drive_in) | ~oe_in;
endmodule

// file: testbench.sv
/*
  Self-checking bench for the charge sequencer: phases, timers, status pins.
  Assumes short tick and precharge counts; reads go through a queue of notes.
*/
`timescale 1ns/10ps
module testbench;
  import charge_seq_pkg::*;
  // ==========================================================================
  // signals
  logic clock_in = 1'b0;
  logic reset_in = 1'b1;
  compare_t cond = '0;
  compare_t cmp;
  logic [DUTY_W-1:0] duty = 5'h0a;
  logic [REG_AW-1:0] addr = 4'h0;
  logic [REG_DW-1:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_q = 1'b0;
  logic [REG_DW-1:0] rdata;
  gate_t gate;
  cur_sel_t cur;
  od_t od_lvl, od_drv, od_oe;
  logic [15:0] exp_q[$], msk_q[$];
  int num_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [15:0] n, v;

  battery_charge_sequencer #(.TICK_LEN(4), .PRECHARGE_TICKS(5)) i_dut (
    .clock_in(clock_in), .reset_in(reset_in), .compare_in(cmp),
    .duty_level_in(duty), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .gate_out(gate), .current_sel_out(cur), .od_level_in(od_lvl),
    .od_drive_out(od_drv), .od_oe_out(od_oe));

  battery_pack_model i_pack (.cond_in(cond), .oe_in(od_oe), .drive_in(od_drv),
    .compare_out(cmp), .level_out(od_lvl));

  // ==========================================================================
  // clock, timeout and the read-data watcher
  initial begin
    forever #25 clock_in = ~clock_in;
  end

  // the ceiling covers the long flash waits with room to spare
  always @(posedge clock_in) begin
    rd_q <= rd;
    cycles++;
    if (cycles == 60000) begin
      num_errors++;
      print_verdict();
    end
  end

  // read data stands only in the cycle after the strobe
  always @(negedge clock_in) begin : watch
    logic [15:0] e, m;
    if (rd_q) begin
      e = exp_q.pop_front();
      m = msk_q.pop_front();
      chk("read data", e, rdata & m);
    end
  end

  // ==========================================================================
  // tasks
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    tests_run++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock_in);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock_in);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m);
    @(posedge clock_in);
    exp_q.push_back(e);
    msk_q.push_back(m);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock_in);
    rd <= 1'b0;
  endtask

  // waits beyond the documented three-edge reaction plus one output cycle
  task automatic hold(input int k);
    repeat (k) @(posedge clock_in);
  endtask

  task automatic state_is(input logic [5:0] e);
    rd_reg(OFS_STATUS, {10'h000, e}, 16'h003f);
  endtask

  // looks at settled pins, then hands back on a rising edge for the next drive
  task automatic pins_are(input logic [2:0] e);
    @(negedge clock_in);
    chk("status pins", {13'h0000, e}, {13'h0000, od_oe});
    @(posedge clock_in);
  endtask

  task automatic count_on(input int k);
    n = 16'h0000;
    v = 16'h0000;
    repeat (k) begin
      @(negedge clock_in);
      n = n + gate.high_side;
      v = v + gate.low_side;
    end
    @(posedge clock_in);
  endtask

  task automatic wait_a_change;
    v = {15'h0000, od_oe.status_out_a};
    n = 16'h0000;
    while (od_oe.status_out_a === v[0] && n < 16'd9000) begin
      @(negedge clock_in);
      n++;
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    void'($urandom(3945));
    hold(5);
    reset_in <= 1'b0;
    rd_reg(OFS_CONTROL, 16'h0000, 16'hffff);
    rd_reg(OFS_SAFETY_LEN, RST_SAFETY_LEN, 16'hffff);
    rd_reg(4'hf, 16'h0000, 16'hffff);
    wr_reg(OFS_STATUS, 16'h0007);
    state_is(6'h00);
    duty <= 5'(1 + $urandom % (PWM_CYCLES - 1));
    // supply, enable, input above battery, temperature ok, deep cell, timer on, forward
    cond <= 14'b10110100010001;
    hold(8);
    state_is(6'h02);
    chk("current select", 16'(CUR_PRECHARGE), 16'(cur));
    pins_are(3'b101);
    cond.temp_ok <= 1'b0;
    hold(40);
    state_is(6'h0a);
    count_on(20);
    chk("high side while suspended", 16'h0000, n + v);
    cond.temp_ok <= 1'b1;
    hold(4);
    state_is(6'h02);
    hold(30);
    state_is(6'h16);
    chk("current select", 16'(CUR_DETECT), 16'(cur));
    pins_are(3'b100);
    cond.battery_replaced <= 1'b1;
    hold(8);
    state_is(6'h02);
    cond.battery_replaced <= 1'b0;
    cond.above_precharge_exit <= 1'b1;
    cond.below_recharge <= 1'b0;
    hold(8);
    state_is(6'h03);
    chk("current select", 16'(CUR_FAST), 16'(cur));
    count_on(20);
    chk("high side cycles", 16'(duty), n);
    chk("low side cycles", 16'(PWM_CYCLES - duty), v);
    cond.hs_peak_limit <= 1'b1;
    hold(8);
    count_on(20);
    chk("high side at peak limit", 16'h0000, n);
    chk("low side at peak limit", 16'(PWM_CYCLES), v);
    // a latched limit may hold the high side off until the period ends
    cond.hs_peak_limit <= 1'b0;
    cond.ls_above_min <= 1'b0;
    hold(30);
    count_on(20);
    chk("high side cycles", 16'(duty), n);
    chk("low side cycles", 16'h0000, v);
    cond.timer_ctl_enabled <= 1'b0;
    cond.at_reg_voltage <= 1'b1;
    cond.at_term_current <= 1'b1;
    hold(8);
    state_is(6'h04);
    cond.timer_ctl_enabled <= 1'b1;
    hold(16);
    state_is(6'h05);
    // released pins read back high through the pull-ups
    rd_reg(OFS_STATUS, 16'h0045, 16'h01ff);
    pins_are(3'b110);
    wr_reg(OFS_SAFETY_LEN, 16'h0003);
    cond.timer_ctl_tied_high <= 1'b1;
    cond.at_reg_voltage <= 1'b0;
    cond.at_term_current <= 1'b0;
    cond.below_recharge <= 1'b1;
    hold(40);
    state_is(6'h03);
    rd_reg(OFS_SAFETY_COUNT, 16'h0000, 16'hffff);
    // the fault would recover at once with the recharge level still low
    cond.timer_ctl_tied_high <= 1'b0;
    cond.below_recharge <= 1'b0;
    hold(30);
    state_is(6'h27);
    pins_are(3'b100);
    wr_reg(OFS_CONTROL, 16'h0001);
    wait_a_change();
    wait_a_change();
    wait_a_change();
    chk("flash half period", 16'(FLASH_HALF_TICKS * 4), n);
    hold(2000);
    @(negedge clock_in);
    v = {15'h0000, od_oe.status_out_a};
    hold(4000);
    pins_are({2'b10, ~v[0]});
    hold(4000);
    pins_are({2'b10, v[0]});
    wr_reg(OFS_CONTROL, 16'h0000);
    cond.timer_ctl_tied_high <= 1'b1;
    cond.charge_enable_n <= 1'b1;
    hold(8);
    state_is(6'h01);
    cond.charge_enable_n <= 1'b0;
    hold(8);
    state_is(6'h03);
    @(negedge clock_in);
    chk("input switch", 16'h0001, {15'h0000, gate.input_block});
    @(posedge clock_in);
    cond.in_above_bat <= 1'b0;
    hold(8);
    @(negedge clock_in);
    chk("input switch", 16'h0000, {15'h0000, gate.input_block});
    @(posedge clock_in);
    cond.supply_ok <= 1'b0;
    hold(8);
    state_is(6'h00);
    pins_are(3'b000);
    hold(2);
    print_verdict();
  end
endmodule
